// file: pwm_ctrl_pkg.sv
/*
 * Shared constants and types for the offline PWM soft-start controller.
 * Assumes a single 250 MHz reference clock for all timing.
 */
`default_nettype none
package pwm_ctrl_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Soft start
  localparam int unsigned SS_STEPS = 32;
  localparam int unsigned SS_LVL_W = 5;
  localparam int unsigned SS_STEP_US = 600;
  localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
  localparam int unsigned SS_TIME_MS = 20;
  localparam int unsigned SS_TIME_CYC = SS_TIME_MS * 1000 * CLK_MHZ;
  // Control unit blanking
  localparam int unsigned BLANK_MS = 20;
  localparam int unsigned BLANK_CYC = BLANK_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // Oscillator and jitter
  localparam int unsigned FSW_HZ = 65000;
  localparam int unsigned FJIT_HZ = 2600;
  localparam int unsigned PER_W = 13;
  localparam int unsigned PER_NOM_CYC = CLK_MHZ * 1000000 / FSW_HZ;
  localparam int unsigned PER_MIN_CYC = CLK_MHZ * 1000000 / (FSW_HZ + FJIT_HZ);
  localparam int unsigned JIT_DEV_CYC = PER_NOM_CYC - PER_MIN_CYC;
  localparam int unsigned JIT_SWEEP_MS = 4;
  localparam int unsigned JIT_SWEEP_CYC = JIT_SWEEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned JIT_STEP_CYC = JIT_SWEEP_CYC / (4 * JIT_DEV_CYC);
  localparam int unsigned JIT_CNT_W = 12;
  // Maximum duty 0.75 as 3/4
  localparam int unsigned DUTY_NUM = 3;
  localparam int unsigned DUTY_SHIFT = 2;
  // Leading edge blanking, rounded up
  localparam int unsigned LEB_NS = 220;
  localparam int unsigned LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Synchronised level inputs: fb low, fb high, ba charged
  localparam int unsigned NSYNC = 3;
  localparam int unsigned NBLANK = 2;

  typedef enum logic [1:0] {SS_OFF, SS_RUN, SS_END} ss_state_t;
  typedef enum logic {JIT_UP, JIT_DOWN} jit_dir_t;
endpackage
`default_nettype wire

// file: ss_if.sv
/*
 * Carrier between the soft-start sequencer and the PWM core.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
interface ss_if;
  import pwm_ctrl_pkg::*;
  logic active;
  logic done;
  logic [SS_LVL_W-1:0] level;
  modport seq (output active, output done, output level);
  modport core (input active, input done, input level);
endinterface
`default_nettype wire

// file: soft_start_seq.sv
/*
 * Soft-start sequencer: 32-step level counter and 20 ms completion timer.
 * Assumes supply_on_i is synchronous and low whenever the supply is below switch-off.
 */
`timescale 1ns/10ps
`default_nettype none
module soft_start_seq
  import pwm_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYC = SS_STEP_CYC,
  parameter int unsigned DONE_CYC = SS_TIME_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic supply_on_i,
  ss_if.seq ss
);
  ss_state_t state_q, state_d;
  logic [CNT_W-1:0] time_q;
  logic [CNT_W-1:0] step_q;
  logic [SS_LVL_W-1:0] level_q;
  logic step_end_w, time_end_w, lvl_max_w;

  assign step_end_w = (step_q == CNT_W'(STEP_CYC - 1));
  assign time_end_w = (time_q == CNT_W'(DONE_CYC - 1));
  assign lvl_max_w = (level_q == SS_LVL_W'(SS_STEPS - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      SS_OFF: if (supply_on_i) state_d = SS_RUN; // see (RQ1)
      SS_RUN: if (time_end_w) state_d = SS_END; // see (RQ4)
      default: state_d = state_q;
    endcase
    if (!supply_on_i) begin
      state_d = SS_OFF; // see (RQ18) see (RQ6)
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= SS_OFF;
      time_q <= '0;
      step_q <= '0;
      level_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q != SS_RUN || !supply_on_i) begin
        time_q <= '0;
        step_q <= '0;
        if (!supply_on_i) begin
          level_q <= '0; // see (RQ18)
        end
      end else begin
        time_q <= time_q + CNT_W'(1);
        step_q <= step_end_w ? '0 : step_q + CNT_W'(1);
        if (step_end_w && !lvl_max_w) begin
          level_q <= level_q + SS_LVL_W'(1); // see (RQ2) see (RQ3)
        end
      end
    end
  end

  assign ss.active = (state_q == SS_RUN);
  assign ss.done = (state_q == SS_END); // see (RQ4)
  assign ss.level = level_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_ss_start_on: assert property (supply_on_i && state_q == SS_OFF |=> ss.active) // see (RQ1)
    else $error("soft start did not begin after supply on");
  a_ss_level_step: assert property ($changed(level_q) && $past(supply_on_i) |->
      level_q == $past(level_q) + SS_LVL_W'(1) && $past(step_end_w)) // see (RQ3)
    else $error("soft start level changed off a step boundary");
  a_ss_done_time: assert property (ss.active && time_end_w && supply_on_i |=> ss.done) // see (RQ4)
    else $error("soft start did not complete at its time");
  a_ss_zero_off: assert property (!supply_on_i |=> level_q == '0 && !ss.active) // see (RQ18)
    else $error("soft start not cleared on supply loss");
endmodule
`default_nettype wire

// file: pwm_softstart_core.sv
/*
 * Current-mode PWM control core: oscillator with jitter and duty limit,
 * PWM set/reset latch with leading edge blanking, soft start and blanking timers.
 * Assumes comparator results from the analog front end; latch resets act
 * combinationally on gate_o, timers use synchronised copies.
 */
// Operation
// (RQ1) Start soft start once supply rises above its switch-on threshold.
// (RQ2) Soft-start level rises in thirty-two counted discrete steps.
// (RQ3) Counter advances one step every 600 us, widening permitted duty.
// (RQ4) Soft start completes 20 ms after switch-on; sink then disabled.
// (RQ5) Permitted on-time grows monotonically from zero to maximum duty.
// (RQ6) Soft start reruns on every auto-restart attempt.
// (RQ7) Oscillator runs at 65 kHz, one latch set per period.
// (RQ8) Normal operation sweeps frequency +/-2.6 kHz over a 4 ms period.
// (RQ9) Jitter stays off during soft start, enabled once it has ended.
// (RQ10) Every on-time ends by 0.75 of the switching period.
// (RQ11) Latch set per oscillator pulse, reset by feedback, soft-start or limit.
// (RQ12) Latch in reset forces gate off immediately.
// (RQ13) Sense current over threshold resets latch, ending the pulse.
// (RQ14) Ignore current sense for 220 ns after each turn-on.
// (RQ15) In burst mode the reduced 0.34 V limit comparison is enabled.
// (RQ16) Burst and auto-restart entry need condition held for 20 ms.
// (RQ17) Auto-restart blanking extends by external delay on the adjust pin.
// (RQ18) Supply below switch-off resets soft start to zero.
// (RQ19) All intervals derive from counting one reference clock.
// (RQ20) Comparators asynchronous: latch resets combinational, counters synchronised.
`timescale 1ns/10ps
`default_nettype none
module pwm_softstart_core
  import pwm_ctrl_pkg::*;
#(
  parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
  parameter int unsigned SS_DONE_CYCLES = SS_TIME_CYC,
  parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic supply_on_i,
  input wire logic fb_cmp_i,
  input wire logic ss_cmp_i,
  input wire logic peak_cmp_i,
  input wire logic burst_cmp_i,
  input wire logic burst_mode_i,
  input wire logic fb_low_i,
  input wire logic fb_high_i,
  input wire logic ba_charged_i,
  output logic gate_o,
  output logic [SS_LVL_W-1:0] soft_start_level_o,
  output logic ss_sink_en_o,
  output logic jitter_on_o,
  output logic burst_entry_o,
  output logic ba_release_o,
  output logic auto_restart_o
);
  // Scale a full-duty limit by the soft-start level over 32
  function automatic logic [PER_W-1:0] ss_scale(input logic [PER_W-1:0] lim,
                                                input logic [SS_LVL_W-1:0] lvl);
    logic [PER_W+SS_LVL_W-1:0] prod;
    prod = (PER_W + SS_LVL_W)'(lim) * (PER_W + SS_LVL_W)'(lvl);
    return prod[PER_W+SS_LVL_W-1:SS_LVL_W];
  endfunction

  ss_if ss ();

  soft_start_seq #(
    .STEP_CYC(SS_STEP_CYCLES),
    .DONE_CYC(SS_DONE_CYCLES)
  ) u_seq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .supply_on_i(supply_on_i),
    .ss(ss)
  );

  // Two-stage synchronisers for counted comparator levels
  logic [NSYNC-1:0] sync1_q, sync2_q, raw_w;
  assign raw_w = {ba_charged_i, fb_high_i, fb_low_i};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_w; // see (RQ20)
      sync2_q <= sync1_q;
    end
  end

  // Oscillator with triangular period jitter
  logic [PER_W-1:0] per_cnt_q, period_q, max_on_q, jit_pos_q;
  logic [PER_W-1:0] period_w, full_on_w, on_lim_w;
  logic [PER_W+1:0] full_x3_w;
  logic [JIT_CNT_W-1:0] jit_tick_q;
  jit_dir_t jit_dir_q;
  logic jit_en_q, wrap_w, jit_step_w, jit_top_w, jit_bot_w;

  assign wrap_w = (per_cnt_q >= period_q - PER_W'(1));
  assign period_w = PER_W'(PER_MIN_CYC) + jit_pos_q; // see (RQ8)
  assign full_x3_w = (PER_W + 2)'(period_w) * (PER_W + 2)'(DUTY_NUM);
  assign full_on_w = full_x3_w[PER_W+DUTY_SHIFT-1:DUTY_SHIFT]; // see (RQ10)
  assign on_lim_w = ss.done ? full_on_w : ss_scale(full_on_w, ss.level); // see (RQ5)
  assign jit_step_w = (jit_tick_q == JIT_CNT_W'(JIT_STEP_CYC - 1));
  assign jit_top_w = (jit_pos_q >= PER_W'(2 * JIT_DEV_CYC));
  assign jit_bot_w = (jit_pos_q == '0);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_cnt_q <= '0;
      period_q <= PER_W'(PER_NOM_CYC);
      max_on_q <= '0;
    end else if (wrap_w) begin
      per_cnt_q <= '0; // see (RQ7) see (RQ19)
      period_q <= period_w;
      max_on_q <= on_lim_w;
    end else begin
      per_cnt_q <= per_cnt_q + PER_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jit_en_q <= 1'b0;
      jit_tick_q <= '0;
      jit_pos_q <= PER_W'(JIT_DEV_CYC);
      jit_dir_q <= JIT_UP;
    end else begin
      jit_en_q <= ss.done; // see (RQ9)
      if (!jit_en_q) begin
        jit_tick_q <= '0;
        jit_pos_q <= PER_W'(JIT_DEV_CYC);
        jit_dir_q <= JIT_UP;
      end else begin
        jit_tick_q <= jit_step_w ? '0 : jit_tick_q + JIT_CNT_W'(1);
        if (jit_step_w) begin
          if (jit_dir_q == JIT_UP) begin
            jit_pos_q <= jit_top_w ? jit_pos_q - PER_W'(1) : jit_pos_q + PER_W'(1);
            jit_dir_q <= jit_top_w ? JIT_DOWN : JIT_UP;
          end else begin
            jit_pos_q <= jit_bot_w ? jit_pos_q + PER_W'(1) : jit_pos_q - PER_W'(1);
            jit_dir_q <= jit_bot_w ? JIT_UP : JIT_DOWN;
          end
        end
      end
    end
  end

  // PWM latch and reset terms
  logic latch_q, run_w, blank_w, lim_trip_w, cs_trip_w, fb_trip_w, ss_trip_w, rst_w;
  logic auto_restart_q;

  assign run_w = (ss.active || ss.done) && !auto_restart_q;
  assign blank_w = (per_cnt_q < PER_W'(LEB_CYC)); // see (RQ14)
  assign lim_trip_w = (per_cnt_q >= max_on_q); // see (RQ10) see (RQ5)
  assign cs_trip_w = !blank_w && (peak_cmp_i || (burst_mode_i && burst_cmp_i)); // see (RQ13) see (RQ15)
  assign fb_trip_w = !blank_w && fb_cmp_i;
  assign ss_trip_w = ss.active && ss_cmp_i;
  assign rst_w = fb_trip_w || ss_trip_w || cs_trip_w || lim_trip_w || !run_w; // see (RQ11)

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_q <= 1'b0;
    end else if (wrap_w && run_w) begin
      latch_q <= 1'b1; // see (RQ11)
    end else if (rst_w) begin
      latch_q <= 1'b0;
    end
  end

  // Gate off at once on any reset term, no clock edge needed
  assign gate_o = latch_q && !rst_w; // see (RQ12) see (RQ20)

  // 20 ms blanking timers: 0 burst entry, 1 overload
  logic [NBLANK-1:0] blank_cond_w, blank_exp_w;
  assign blank_cond_w = {sync2_q[1], sync2_q[0]} & {NBLANK{run_w}};

  for (genvar i = 0; i < NBLANK; i++) begin : g_blank
    logic [CNT_W-1:0] cnt_q;
    assign blank_exp_w[i] = (cnt_q == CNT_W'(BLANK_CYCLES));
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_q <= '0;
      end else if (!blank_cond_w[i]) begin
        cnt_q <= '0; // see (RQ16)
      end else if (!blank_exp_w[i]) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  logic burst_entry_q, ba_release_q, sink_en_q, jit_out_q;
  logic [SS_LVL_W-1:0] level_out_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_entry_q <= 1'b0;
      ba_release_q <= 1'b0;
      auto_restart_q <= 1'b0;
      sink_en_q <= 1'b0;
      jit_out_q <= 1'b0;
      level_out_q <= '0;
    end else begin
      burst_entry_q <= blank_exp_w[0]; // see (RQ16)
      ba_release_q <= blank_exp_w[1]; // see (RQ17)
      if (blank_exp_w[1] && sync2_q[2]) begin
        auto_restart_q <= 1'b1; // see (RQ17)
      end else if (!supply_on_i) begin
        auto_restart_q <= 1'b0; // see (RQ6)
      end
      sink_en_q <= ss.active; // see (RQ4)
      jit_out_q <= jit_en_q;
      level_out_q <= ss.level;
    end
  end

  assign soft_start_level_o = level_out_q;
  assign ss_sink_en_o = sink_en_q;
  assign jitter_on_o = jit_out_q;
  assign burst_entry_o = burst_entry_q;
  assign ba_release_o = ba_release_q;
  assign auto_restart_o = auto_restart_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_gate_needs_latch: assert property (gate_o |-> latch_q && run_w) // see (RQ12)
    else $error("gate high without set latch");
  a_peak_trip_off: assert property (!blank_w && peak_cmp_i |-> !gate_o ##1 !latch_q) // see (RQ13)
    else $error("peak limit did not end pulse");
  a_burst_limit_off: assert property (burst_mode_i && burst_cmp_i && !blank_w |-> !gate_o) // see (RQ15)
    else $error("burst limit did not end pulse");
  a_duty_max: assert property (gate_o |-> per_cnt_q < max_on_q && // see (RQ10)
      ((PER_W + 2)'(max_on_q) << DUTY_SHIFT) <= (PER_W + 2)'(period_q) * (PER_W + 2)'(DUTY_NUM))
    else $error("on-time beyond duty limit");
  a_ss_trip_off: assert property (ss.active && ss_cmp_i |-> !gate_o) // see (RQ11)
    else $error("soft start trip did not end pulse");
  a_osc_set: assert property (wrap_w && run_w |=> latch_q && per_cnt_q == '0) // see (RQ7)
    else $error("oscillator pulse did not set latch");
  a_jitter_idle: assert property (ss.active |=> jit_pos_q == PER_W'(JIT_DEV_CYC) && !jit_en_q) // see (RQ9)
    else $error("jitter active during soft start");
  a_leb_window: assert property ($rose(latch_q) |-> blank_w [*8]) // see (RQ14)
    else $error("blanking window too short");
  a_restart_blank: assert property ($rose(auto_restart_q) |-> $past(blank_exp_w[1])) // see (RQ16)
    else $error("auto restart without full blanking");
endmodule
`default_nettype wire

// file: sense_model.sv
/*
 * Far side model: switch current ramp seen by the limit comparators.
 * Assumes gate_i is the gate drive; thresholds are on-time cycles, all-ones is off.
 */
`timescale 1ns/10ps
`default_nettype none
module sense_model (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic [15:0] fb_thr_i,
  input wire logic [15:0] pk_thr_i,
  input wire logic [15:0] bs_thr_i,
  output logic fb_cmp_o,
  output logic peak_cmp_o,
  output logic burst_cmp_o
);
  logic [15:0] on_q;
  initial begin
    on_q = 16'h0000;
    fb_cmp_o = 1'b0;
    peak_cmp_o = 1'b0;
    burst_cmp_o = 1'b0;
  end
  // Current ramps while on, collapses once the switch opens
  always @(posedge clk_i) begin
    on_q <= gate_i ? on_q + 16'h0001 : 16'h0000;
    fb_cmp_o <= gate_i && (on_q + 16'h0001 >= fb_thr_i);
    peak_cmp_o <= gate_i && (on_q + 16'h0001 >= pk_thr_i);
    burst_cmp_o <= gate_i && (on_q + 16'h0001 >= bs_thr_i);
  end
endmodule
`default_nettype wire

// file: offline_pwm_softstart_control_tb_top.sv
/*
 * Self-checking bench for the PWM soft-start core with a current sense model.
 * Assumes shortened soft start and blanking counts; 250 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module offline_pwm_softstart_control_tb_top;
  import pwm_ctrl_pkg::*;
  localparam int STEP = 20;
  localparam int DONE = 700;
  localparam int BLANK = 50;
  localparam logic [15:0] OFF = 16'hffff;
  logic clk_i = 0, arst_n_i = 0, supply_on_i = 0, ss_cmp_i = 0, burst_mode_i = 0;
  logic fb_low_i = 0, fb_high_i = 0, ba_charged_i = 0, gate_q = 0, mon_en = 0;
  logic fb_cmp_i, peak_cmp_i, burst_cmp_i, gate_o, ss_sink_en_o, jitter_on_o;
  logic burst_entry_o, ba_release_o, auto_restart_o;
  logic [SS_LVL_W-1:0] soft_start_level_o, lvl;
  logic [15:0] fb_thr = OFF, pk_thr = OFF, bs_thr = OFF;
  int miscompares = 0, checked = 0, rises = 0, per_c = 0, on_c = 0, last_per = 0, last_on = 0;
  int pmin = 99999, pmax = 0, sink_n, steps, last_i, r;

  pwm_softstart_core #(.SS_STEP_CYCLES(STEP), .SS_DONE_CYCLES(DONE), .BLANK_CYCLES(BLANK)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .supply_on_i(supply_on_i), .fb_cmp_i(fb_cmp_i),
    .ss_cmp_i(ss_cmp_i), .peak_cmp_i(peak_cmp_i), .burst_cmp_i(burst_cmp_i),
    .burst_mode_i(burst_mode_i), .fb_low_i(fb_low_i), .fb_high_i(fb_high_i),
    .ba_charged_i(ba_charged_i), .gate_o(gate_o), .soft_start_level_o(soft_start_level_o),
    .ss_sink_en_o(ss_sink_en_o), .jitter_on_o(jitter_on_o), .burst_entry_o(burst_entry_o),
    .ba_release_o(ba_release_o), .auto_restart_o(auto_restart_o));

  sense_model model (.clk_i(clk_i), .gate_i(gate_o), .fb_thr_i(fb_thr), .pk_thr_i(pk_thr),
    .bs_thr_i(bs_thr), .fb_cmp_o(fb_cmp_i), .peak_cmp_o(peak_cmp_i), .burst_cmp_o(burst_cmp_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_rises(input int n);
    int t;
    t = rises + n;
    for (int i = 0; i < 9000 && rises < t; i++) cyc(1);
    chk(rises >= t, 1'b1);
  endtask

  function automatic int exp_on(input int thr, input int per);
    int t, m;
    t = thr < LEB_CYC ? LEB_CYC : thr;
    m = per * DUTY_NUM / (1 << DUTY_SHIFT);
    return t < m ? t : m;
  endfunction

  task automatic run_case(input int fb, input int pk, input int bs, input logic bm);
    int e, thr;
    fb_thr = fb[15:0];
    pk_thr = pk[15:0];
    bs_thr = bs[15:0];
    burst_mode_i = bm;
    wait_rises(2);
    thr = fb < pk ? fb : pk;
    if (bm && bs < thr) thr = bs;
    e = exp_on(thr, last_per);
    chk(last_on >= e - 1 && last_on <= e + 1, 1'b1);
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Pulse timing and immediate turn-off watch
  always @(negedge clk_i) begin
    if (gate_o === 1'b1 && gate_q === 1'b0) begin
      last_per = per_c + 1;
      last_on = on_c;
      per_c = 0;
      on_c = 0;
      rises++;
      if (mon_en && rises > 2) begin
        pmin = last_per < pmin ? last_per : pmin;
        pmax = last_per > pmax ? last_per : pmax;
      end
    end else per_c++;
    on_c += (gate_o === 1'b1);
    if (mon_en && per_c >= LEB_CYC && (peak_cmp_i || fb_cmp_i || (burst_cmp_i && burst_mode_i)))
      chk(gate_o, 1'b0);
    gate_q = gate_o;
  end

  initial begin
    #360000;
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hdef5_6977));
    cyc(2);
    arst_n_i = 1;
    chk({gate_o, ss_sink_en_o, soft_start_level_o, jitter_on_o, auto_restart_o}, 0);
    cyc(3);
    chk(ss_sink_en_o, 1'b0);
    supply_on_i = 1;
    sink_n = 0;
    steps = 0;
    last_i = 0;
    lvl = 0;
    for (int i = 0; i < 900; i++) begin
      cyc(1);
      ss_cmp_i = (i >= 400 && i < 410);
      if (i > 400 && i < 410) chk(gate_o, 1'b0);
      if (ss_sink_en_o === 1'b1) begin
        if (sink_n == 0) chk(i <= 2, 1'b1);
        sink_n++;
        chk(jitter_on_o, 1'b0);
      end
      if (soft_start_level_o !== lvl) begin
        chk(soft_start_level_o, lvl + 1'b1);
        if (steps > 0) chk(i - last_i, STEP);
        lvl = soft_start_level_o;
        steps++;
        last_i = i;
      end
    end
    chk(steps, SS_STEPS - 1);
    chk(sink_n >= DONE - 1 && sink_n <= DONE + 1, 1'b1);
    chk({ss_sink_en_o, jitter_on_o}, 2'b01);
    wait_rises(1);
    mon_en = 1;
    run_case(OFF, OFF, OFF, 0);
    run_case(300, OFF, OFF, 0);
    for (int k = 0; k < 2; k++) run_case(OFF, 60 + $urandom % 2000, OFF, 0);
    run_case(OFF, 10, OFF, 0);
    run_case(OFF, OFF, 200, 0);
    run_case(OFF, OFF, 200, 1);
    chk(pmin >= PER_NOM_CYC - JIT_DEV_CYC && pmax <= PER_NOM_CYC + JIT_DEV_CYC, 1'b1);
    chk(pmax > pmin, 1'b1);
    mon_en = 0;
    burst_mode_i = 0;
    {fb_high_i, fb_low_i} = 2'b11;
    cyc(5 + $urandom % (BLANK - 10));
    {fb_high_i, fb_low_i} = 2'b00;
    cyc(5);
    chk({ba_release_o, burst_entry_o}, 2'b00);
    {fb_high_i, fb_low_i} = 2'b11;
    cyc(BLANK - 1);
    chk({ba_release_o, burst_entry_o}, 2'b00);
    cyc(6);
    chk({ba_release_o, burst_entry_o}, 2'b11);
    chk(auto_restart_o, 1'b0);
    fb_low_i = 0;
    cyc(4);
    chk(burst_entry_o, 1'b0);
    ba_charged_i = 1;
    cyc(5);
    chk(auto_restart_o, 1'b1);
    r = rises;
    cyc(4500);
    chk(rises, r);
    {fb_high_i, ba_charged_i, supply_on_i} = 3'b000;
    cyc(3);
    chk({auto_restart_o, ss_sink_en_o, soft_start_level_o}, 0);
    supply_on_i = 1;
    cyc(4);
    chk(ss_sink_en_o, 1'b1);
    cyc(2 * STEP + 4);
    chk(soft_start_level_o >= 1, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
